// [verification/ssrt_link_master.sv]
// Model of the external master that clocks the serial link
`timescale 1ns/100ps
`default_nettype none
module ssrt_link_master
#(
  parameter int HALF_NS = 80
)
(
  output var logic ck, // Bit clock to the block
  output var logic dt_o, // Data offered by the master
  input wire logic dt_i // Data line as seen on the wire
);
  // Clock stands low between frames
  initial
  begin
    ck = 1'b0;
    dt_o = 1'b0;
  end

  // ****************************************************************
  // Frames
  // ****************************************************************
  // Send n bits LSB first; data set while the clock is low
  task automatic send(input logic [8:0] w, input int n);
    #3;
    for (int k = 0; k < n; k++)
    begin
      dt_o = w[k];
      #(HALF_NS) ck = 1'b1;
      #(HALF_NS) ck = 1'b0;
    end
    // Released line shows the inverse of its last value
    dt_o = ~dt_o;
    #(HALF_NS);
  endtask

  // Clock n bits out of the block, sampled at the end of the high phase
  task automatic take(input int n, output logic [8:0] w);
    w = 9'h000;
    #3;
    for (int k = 0; k < n; k++)
    begin
      #(HALF_NS) ck = 1'b1;
      #(HALF_NS) w[k] = dt_i;
      ck = 1'b0;
    end
    #(HALF_NS);
  endtask
endmodule
`default_nettype wire

// [verification/testbench.sv]
// Self-checking bench for the synchronous slave serial block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  typedef struct packed {
    logic wr;
    logic [3:0] idx;
    logic [7:0] dat;
    logic [7:0] exp;
  } ssrt_row_type;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [5:0] adr = 6'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h00000000;
  logic [31:0] rdat;
  logic ack;
  logic dt0_o;
  logic dt0_oe;
  logic dt1_o;
  logic dt1_oe;
  logic wake;
  logic irq;
  logic [15:0] irq_vec;
  wire logic ck_line;
  wire logic m_dt;
  wire logic dt_line;
  int failures = 0;
  int checks_done = 0;
  logic [8:0] got;
  ssrt_row_type rows [0:20] = '{
    '{1'b0, 4'h0, 8'h00, 8'h00}, '{1'b0, 4'h1, 8'h00, 8'h02}, '{1'b0, 4'h2, 8'h00, 8'h40},
    '{1'b0, 4'h3, 8'h00, 8'h00}, '{1'b0, 4'h4, 8'h00, 8'h00}, '{1'b0, 4'h5, 8'h00, 8'h10},
    '{1'b0, 4'h7, 8'h00, 8'h00}, '{1'b0, 4'h8, 8'h00, 8'h00}, '{1'b0, 4'h9, 8'h00, 8'h00},
    '{1'b0, 4'hA, 8'h00, ssrt_pkg::RST_PORTB_DIR}, '{1'b0, 4'hB, 8'h00, 8'h00},
    '{1'b1, 4'hA, 8'h5A, 8'h00}, '{1'b0, 4'hA, 8'h00, 8'h5A}, '{1'b1, 4'h8, 8'h80, 8'h00},
    '{1'b0, 4'h8, 8'h00, 8'h80}, '{1'b1, 4'h9, 8'h01, 8'h00}, '{1'b0, 4'h9, 8'h00, 8'h01},
    '{1'b1, 4'h8, 8'h00, 8'h00}, '{1'b1, 4'h9, 8'h00, 8'h00}, '{1'b1, 4'hB, 8'h77, 8'h00},
    '{1'b0, 4'hB, 8'h00, 8'h00}};

  always #10 clk = ~clk;

  // Both pin pairs share one wire so either selection works
  assign dt_line = dt0_oe ? dt0_o : (dt1_oe ? dt1_o : m_dt);

  ssrt_core #(.FIFO_DEPTH(2)) ssrt_core_i (.CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .CK0_I(ck_line), .CK1_I(ck_line), .DT0_I(dt_line),
    .DT1_I(dt_line), .DT0_O(dt0_o), .DT0_OE(dt0_oe), .DT1_O(dt1_o), .DT1_OE(dt1_oe),
    .WAKE(wake), .IRQ(irq), .IRQ_VECTOR(irq_vec));

  ssrt_link_master ssrt_link_master_i (.ck(ck_line), .dt_o(m_dt), .dt_i(dt_line));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wb(input logic w, input logic [3:0] idx, input logic [7:0] d,
                    output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= 4'hF;
    wdat <= {24'h000000, d};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 50)
      failures++;
  endtask

  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, idx, d, q);
  endtask

  task automatic rd_chk(input string what, input logic [3:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    wb(1'b0, idx, 8'h00, q);
    check(what, {8'h00, q}, {8'h00, exp});
  endtask

  task automatic wait_wake;
    int n;
    n = 0;
    while (wake !== 1'b1 && n < 40)
    begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    #1000000;
    failures++;
    give_verdict();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i])
    begin
      if (rows[i].wr)
        wr(rows[i].idx, rows[i].dat);
      else
        rd_chk("register", rows[i].idx, rows[i].exp);
    end
    // Reception with interrupts, single receive bit set as well
    wr(ssrt_pkg::IDX_TX_STATUS, 8'h10);
    wr(ssrt_pkg::IDX_PERIPHERAL_IRQ_ENABLE_REG1, 8'h20);
    wr(ssrt_pkg::IDX_IRQ_CTRL, 8'hC0);
    wr(ssrt_pkg::IDX_RX_STATUS, 8'hB0);
    rd_chk("rx idle", ssrt_pkg::IDX_BAUD, 8'h00);
    ssrt_link_master_i.send(9'h0A5, 8);
    wait_wake();
    check("wake", {15'h0000, wake}, 16'h0001);
    repeat (2) @(posedge clk);
    check("irq", {15'h0000, irq}, 16'h0001);
    check("vector", irq_vec, ssrt_pkg::VECTOR_ADDR);
    rd_chk("flags", ssrt_pkg::IDX_PERIPHERAL_IRQ_FLAG_REG1, 8'h30);
    rd_chk("rx data", ssrt_pkg::IDX_RX_DATA, 8'hA5);
    rd_chk("flags", ssrt_pkg::IDX_PERIPHERAL_IRQ_FLAG_REG1, 8'h10);
    // Nine-bit word
    wr(ssrt_pkg::IDX_RX_STATUS, 8'hF0);
    ssrt_link_master_i.send(9'h13C, 9);
    wait_wake();
    rd_chk("rx status", ssrt_pkg::IDX_RX_STATUS, 8'hF1);
    rd_chk("rx data", ssrt_pkg::IDX_RX_DATA, 8'h3C);
    rd_chk("rx status", ssrt_pkg::IDX_RX_STATUS, 8'hF0);
    // Overrun, cleared by continuous receive and then by port enable
    wr(ssrt_pkg::IDX_RX_STATUS, 8'h90);
    ssrt_link_master_i.send(9'h011, 8);
    ssrt_link_master_i.send(9'h022, 8);
    ssrt_link_master_i.send(9'h033, 8);
    repeat (8) @(posedge clk);
    rd_chk("rx status", ssrt_pkg::IDX_RX_STATUS, 8'h92);
    wr(ssrt_pkg::IDX_RX_STATUS, 8'h80);
    rd_chk("rx status", ssrt_pkg::IDX_RX_STATUS, 8'h80);
    rd_chk("rx data", ssrt_pkg::IDX_RX_DATA, 8'h11);
    rd_chk("rx data", ssrt_pkg::IDX_RX_DATA, 8'h22);
    wr(ssrt_pkg::IDX_RX_STATUS, 8'h90);
    ssrt_link_master_i.send(9'h044, 8);
    ssrt_link_master_i.send(9'h055, 8);
    ssrt_link_master_i.send(9'h066, 8);
    repeat (8) @(posedge clk);
    rd_chk("rx status", ssrt_pkg::IDX_RX_STATUS, 8'h92);
    wr(ssrt_pkg::IDX_RX_STATUS, 8'h00);
    rd_chk("rx status", ssrt_pkg::IDX_RX_STATUS, 8'h00);
    rd_chk("flags", ssrt_pkg::IDX_PERIPHERAL_IRQ_FLAG_REG1, 8'h10);
    // Clock master selected: the link must not shift
    wr(ssrt_pkg::IDX_TX_STATUS, 8'h90);
    wr(ssrt_pkg::IDX_RX_STATUS, 8'h90);
    ssrt_link_master_i.send(9'h077, 8);
    repeat (8) @(posedge clk);
    rd_chk("flags", ssrt_pkg::IDX_PERIPHERAL_IRQ_FLAG_REG1, 8'h10);
    // Transmission with a pending byte, no global enable
    wr(ssrt_pkg::IDX_RX_STATUS, 8'h80);
    wr(ssrt_pkg::IDX_TX_STATUS, 8'h30);
    wr(ssrt_pkg::IDX_PERIPHERAL_IRQ_ENABLE_REG1, 8'h10);
    wr(ssrt_pkg::IDX_IRQ_CTRL, 8'h40);
    wr(ssrt_pkg::IDX_TX_DATA, 8'h5A);
    wr(ssrt_pkg::IDX_TX_DATA, 8'hC3);
    rd_chk("flags", ssrt_pkg::IDX_PERIPHERAL_IRQ_FLAG_REG1, 8'h00);
    check("wake", {15'h0000, wake}, 16'h0000);
    check("pin enables", {14'h0000, dt0_oe, dt1_oe}, 16'h0002);
    ssrt_link_master_i.take(8, got);
    check("tx word", {7'h00, got}, 16'h005A);
    repeat (8) @(posedge clk);
    rd_chk("flags", ssrt_pkg::IDX_PERIPHERAL_IRQ_FLAG_REG1, 8'h10);
    check("wake", {15'h0000, wake}, 16'h0001);
    check("irq", {15'h0000, irq}, 16'h0000);
    check("vector", irq_vec, 16'h0000);
    ssrt_link_master_i.take(8, got);
    check("tx word", {7'h00, got}, 16'h00C3);
    give_verdict();
  end
endmodule
`default_nettype wire

// [verilog/ssrt_core.sv]
// Synchronous slave serial receiver/transmitter with classic Wishbone registers
//
// The register addresses and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module ssrt_core
#(
  parameter int FIFO_DEPTH = 2
)
(
  input wire logic CLK, // System clock, 50 MHz
  input wire logic RST_N, // Asynchronous reset, active low
  input wire logic WB_CYC_I, // Wishbone cycle
  input wire logic WB_STB_I, // Wishbone strobe
  input wire logic WB_WE_I, // Wishbone write enable
  input wire logic [5:0] WB_ADR_I, // Wishbone byte address
  input wire logic [3:0] WB_SEL_I, // Wishbone byte lanes
  input wire logic [31:0] WB_DAT_I, // Wishbone write data
  output logic [31:0] WB_DAT_O, // Wishbone read data
  output logic WB_ACK_O, // Wishbone acknowledge
  input wire logic CK0_I, // Bit clock, default pin
  input wire logic CK1_I, // Bit clock, alternate pin
  input wire logic DT0_I, // Data in, default pin
  input wire logic DT1_I, // Data in, alternate pin
  output logic DT0_O, // Data out, default pin
  output logic DT0_OE, // Data drive enable, default pin
  output logic DT1_O, // Data out, alternate pin
  output logic DT1_OE, // Data drive enable, alternate pin
  output logic WAKE, // Wake request to the core
  output logic IRQ, // Vectored interrupt request
  output logic [15:0] IRQ_VECTOR // Vector address while IRQ is high
);

  localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;

  function automatic logic pick(input logic [1:0] v, input logic s);
    pick = s ? v[1] : v[0];
  endfunction

  // ****************************************************************
  // Registers and wires
  // ****************************************************************
  logic [7:0] rx_status, tx_status, baud, irq_ctrl, peripheral_irq_enable_reg1, alt0, alt1, portb_dir;
  logic [1:0] ck_m, ck_s, dt_m, dt_s;
  logic ck_d, ck_now, dt_now, rise, fall, sample_edge, drive_edge;
  logic port_en, slave_mode, rx_run, tx_run, rx_done, fifo_full, push, pop, overrun, receive_irq_flag;
  logic [8:0] rx_sr, next_rx_word, transmit_shift_reg;
  logic [3:0] rx_cnt, rx_last, tx_cnt, tx_last, idx;
  ssrt_pkg::ssrt_word_type fifo [FIFO_DEPTH];
  ssrt_pkg::ssrt_word_type head;
  logic [PW-1:0] wr_ptr, rd_ptr;
  logic [PW:0] fifo_cnt;
  logic [7:0] tx_buf;
  logic tx_buf_valid, tsr_full, tx_word_done, tsr_load, transmit_irq_flag, dt_out, bus_req, bus_wr, bus_rd;
  logic [31:0] next_rdata;

  // ****************************************************************
  // Pin synchronisers and bit clock edges
  // ****************************************************************
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ck_m <= 2'h0;
      ck_s <= 2'h0;
      dt_m <= 2'h0;
      dt_s <= 2'h0;
      ck_d <= 1'b0;
    end
    else
    begin
      ck_m <= {CK1_I, CK0_I};
      ck_s <= ck_m;
      dt_m <= {DT1_I, DT0_I};
      dt_s <= dt_m;
      ck_d <= ck_now;
    end
  end

  assign ck_now = pick(ck_s, alt1[ssrt_pkg::ALT1_CLK_SEL]);
  assign dt_now = pick(dt_s, alt0[ssrt_pkg::ALT0_DATA_SEL]);
  assign rise = ck_now & ~ck_d;
  assign fall = ~ck_now & ck_d;
  assign sample_edge = baud[ssrt_pkg::BC_CLK_INVERT] ? fall : rise;
  assign drive_edge = baud[ssrt_pkg::BC_CLK_INVERT] ? rise : fall;

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  assign port_en = rx_status[ssrt_pkg::RS_PORT_EN];
  assign slave_mode = port_en & tx_status[ssrt_pkg::TS_CLOCKED]
    & ~tx_status[ssrt_pkg::TS_CLK_MASTER];
  // Single-receive bit is never looked at; receiver runs only in slave mode with continuous receive set and transmit off
  assign rx_run = slave_mode & rx_status[ssrt_pkg::RS_CONT_EN]
    & ~tx_status[ssrt_pkg::TS_TX_EN];
  assign tx_run = slave_mode & tx_status[ssrt_pkg::TS_TX_EN];

  // ****************************************************************
  // Receive shifter
  // ****************************************************************
  assign rx_last = rx_status[ssrt_pkg::RS_NINTH_EN] ? ssrt_pkg::LAST_BIT_9
    : ssrt_pkg::LAST_BIT_8;
  assign rx_done = rx_run & sample_edge & (rx_cnt == rx_last);

  always_comb
  begin
    next_rx_word = rx_sr;
    next_rx_word[rx_cnt] = dt_now;
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rx_sr <= 9'h000;
      rx_cnt <= 4'h0;
    end
    else if (!rx_run)
    begin
      rx_sr <= 9'h000;
      rx_cnt <= 4'h0;
    end
    else if (sample_edge)
    begin
      rx_sr <= next_rx_word;
      rx_cnt <= rx_done ? 4'h0 : rx_cnt + 4'h1;
    end
  end

  // ****************************************************************
  // Receive FIFO and overrun
  // ****************************************************************
  assign fifo_full = (fifo_cnt == (PW+1)'(FIFO_DEPTH));
  assign push = rx_done & ~fifo_full;
  assign overrun = rx_done & fifo_full;
  assign pop = bus_rd & (idx == ssrt_pkg::IDX_RX_DATA) & (fifo_cnt != '0);
  assign receive_irq_flag = (fifo_cnt != '0);
  assign head = fifo[rd_ptr];

  always_ff @(posedge CLK)
  begin
    if (push)
    begin
      fifo[wr_ptr].data <= next_rx_word[7:0];
      fifo[wr_ptr].ninth <= rx_status[ssrt_pkg::RS_NINTH_EN] & next_rx_word[8];
    end
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fifo_cnt <= '0;
    end
    else if (!port_en)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fifo_cnt <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == PW'(FIFO_DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == PW'(FIFO_DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      if (push && !pop)
        fifo_cnt <= fifo_cnt + 1'b1;
      else if (pop && !push)
        fifo_cnt <= fifo_cnt - 1'b1;
    end
  end

  // ****************************************************************
  // Transmit buffer and shifter
  // ****************************************************************
  assign tx_last = tx_status[ssrt_pkg::TS_NINTH_EN] ? ssrt_pkg::LAST_BIT_9
    : ssrt_pkg::LAST_BIT_8;
  assign tx_word_done = tx_run & tsr_full & drive_edge & (tx_cnt == tx_last);
  assign tsr_load = tx_run & tx_buf_valid & (~tsr_full | tx_word_done);
  assign transmit_irq_flag = ~tx_buf_valid;

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      tx_buf <= 8'h00;
      tx_buf_valid <= 1'b0;
    end
    else if (!port_en)
      tx_buf_valid <= 1'b0;
    else if (bus_wr && idx == ssrt_pkg::IDX_TX_DATA && WB_SEL_I[0])
    begin
      tx_buf <= WB_DAT_I[7:0];
      tx_buf_valid <= 1'b1;
    end
    else if (tsr_load)
      tx_buf_valid <= 1'b0;
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      transmit_shift_reg <= 9'h000;
      tsr_full <= 1'b0;
      tx_cnt <= 4'h0;
    end
    else if (!tx_run)
    begin
      tsr_full <= 1'b0;
      tx_cnt <= 4'h0;
    end
    else if (tsr_load)
    begin
      transmit_shift_reg <= {tx_status[ssrt_pkg::TS_NINTH_BIT], tx_buf};
      tsr_full <= 1'b1;
      tx_cnt <= 4'h0;
    end
    else if (tsr_full && drive_edge)
    begin
      tsr_full <= ~tx_word_done;
      tx_cnt <= tx_word_done ? 4'h0 : tx_cnt + 4'h1;
    end
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      dt_out <= 1'b1;
    else
      dt_out <= tsr_full ? transmit_shift_reg[tx_cnt] : 1'b1;
  end

  assign DT0_O = dt_out;
  assign DT1_O = dt_out;
  assign DT0_OE = tx_run & ~alt0[ssrt_pkg::ALT0_DATA_SEL];
  assign DT1_OE = tx_run & alt0[ssrt_pkg::ALT0_DATA_SEL];

  // ****************************************************************
  // Wishbone slave
  // ****************************************************************
  assign idx = WB_ADR_I[5:2];
  assign bus_req = WB_CYC_I & WB_STB_I;
  assign bus_wr = bus_req & WB_ACK_O & WB_WE_I;
  assign bus_rd = bus_req & WB_ACK_O & ~WB_WE_I;

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    unique case (idx)
      ssrt_pkg::IDX_RX_STATUS:
        next_rdata[7:0] = {rx_status[7:3], 1'b0,
          rx_status[ssrt_pkg::RS_OVERRUN], head.ninth};
      ssrt_pkg::IDX_TX_STATUS:
        next_rdata[7:0] = {tx_status[7:2], ~tsr_full,
          tx_status[ssrt_pkg::TS_NINTH_BIT]};
      ssrt_pkg::IDX_BAUD:
        next_rdata[7:0] = {baud[7], ~rx_run, baud[5:0]};
      ssrt_pkg::IDX_IRQ_CTRL:
        next_rdata[7:0] = irq_ctrl;
      ssrt_pkg::IDX_PERIPHERAL_IRQ_ENABLE_REG1:
        next_rdata[7:0] = peripheral_irq_enable_reg1;
      ssrt_pkg::IDX_PERIPHERAL_IRQ_FLAG_REG1:
        next_rdata[7:0] = {2'h0, receive_irq_flag, transmit_irq_flag, 4'h0};
      ssrt_pkg::IDX_RX_DATA:
        next_rdata[7:0] = head.data;
      ssrt_pkg::IDX_ALT0:
        next_rdata[7:0] = alt0;
      ssrt_pkg::IDX_ALT1:
        next_rdata[7:0] = alt1;
      ssrt_pkg::IDX_PORTB_DIR:
        next_rdata[7:0] = portb_dir;
      default:
        next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end
    else
    begin
      WB_ACK_O <= bus_req & ~WB_ACK_O;
      if (bus_req && !WB_ACK_O)
        WB_DAT_O <= next_rdata;
    end
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      tx_status <= ssrt_pkg::RST_CTRL;
      baud <= ssrt_pkg::RST_CTRL;
      irq_ctrl <= ssrt_pkg::RST_CTRL;
      peripheral_irq_enable_reg1 <= ssrt_pkg::RST_CTRL;
      alt0 <= ssrt_pkg::RST_CTRL;
      alt1 <= ssrt_pkg::RST_CTRL;
      portb_dir <= ssrt_pkg::RST_PORTB_DIR;
    end
    else if (bus_wr && WB_SEL_I[0])
    begin
      unique case (idx)
        ssrt_pkg::IDX_TX_STATUS: tx_status <= WB_DAT_I[7:0] & ssrt_pkg::TX_STATUS_WMASK;
        ssrt_pkg::IDX_BAUD: baud <= WB_DAT_I[7:0];
        ssrt_pkg::IDX_IRQ_CTRL: irq_ctrl <= WB_DAT_I[7:0];
        ssrt_pkg::IDX_PERIPHERAL_IRQ_ENABLE_REG1: peripheral_irq_enable_reg1 <= WB_DAT_I[7:0];
        ssrt_pkg::IDX_ALT0: alt0 <= WB_DAT_I[7:0];
        ssrt_pkg::IDX_ALT1: alt1 <= WB_DAT_I[7:0];
        ssrt_pkg::IDX_PORTB_DIR: portb_dir <= WB_DAT_I[7:0];
        default: portb_dir <= portb_dir;
      endcase
    end
  end

  // Control bits of the receive status register plus the sticky overrun
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      rx_status <= ssrt_pkg::RST_CTRL;
    else
    begin
      if (bus_wr && WB_SEL_I[0] && idx == ssrt_pkg::IDX_RX_STATUS)
        rx_status[7:3] <= WB_DAT_I[7:3];
      if (overrun)
        rx_status[ssrt_pkg::RS_OVERRUN] <= 1'b1;
      else if (!port_en || !rx_status[ssrt_pkg::RS_CONT_EN])
        rx_status[ssrt_pkg::RS_OVERRUN] <= 1'b0;
    end
  end

  // ****************************************************************
  // Wake and interrupt outputs
  // ****************************************************************
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      WAKE <= 1'b0;
      IRQ <= 1'b0;
      IRQ_VECTOR <= 16'h0000;
    end
    else
    begin
      WAKE <= irq_ctrl[ssrt_pkg::IC_PERIPH_EN]
        & ((receive_irq_flag & peripheral_irq_enable_reg1[ssrt_pkg::PI_RX]) | (transmit_irq_flag & peripheral_irq_enable_reg1[ssrt_pkg::PI_TX]));
      IRQ <= WAKE & irq_ctrl[ssrt_pkg::IC_GLOBAL_EN];
      IRQ_VECTOR <= (WAKE & irq_ctrl[ssrt_pkg::IC_GLOBAL_EN])
        ? ssrt_pkg::VECTOR_ADDR : 16'h0000;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  AST_RX_PUSH: assert property (rx_done && !fifo_full && !pop
    |=> receive_irq_flag && fifo_cnt == $past(fifo_cnt) + 1'b1) else $error("completed word not stored");
  AST_OVERRUN_SET: assert property (overrun |=> rx_status[ssrt_pkg::RS_OVERRUN])
    else $error("overrun not flagged");
  AST_OVERRUN_CLR: assert property (!rx_status[ssrt_pkg::RS_CONT_EN] && !overrun
    |=> !rx_status[ssrt_pkg::RS_OVERRUN]) else $error("overrun not cleared");
  AST_NO_SHIFT: assert property (!slave_mode |=> rx_cnt == 4'h0 && !tsr_full)
    else $error("shifting outside slave mode");
  AST_RX_EDGE: assert property (rx_run && !sample_edge |=> $stable(rx_cnt))
    else $error("receive advanced without clock edge");
  AST_TX_WRITE: assert property (bus_wr && idx == ssrt_pkg::IDX_TX_DATA && WB_SEL_I[0]
    |=> !transmit_irq_flag) else $error("transmit flag not cleared by write");
  // A write landing on the reload edge keeps the buffer full, so it is excluded
  AST_TX_RELOAD: assert property (tx_word_done && tx_buf_valid
    && !(bus_wr && idx == ssrt_pkg::IDX_TX_DATA) |=> tsr_full && transmit_irq_flag && tx_cnt == 4'h0)
    else $error("pending byte not reloaded");
  AST_WAKE_VEC: assert property (receive_irq_flag && peripheral_irq_enable_reg1[ssrt_pkg::PI_RX] && irq_ctrl[7:6] == 2'h3
    && !pop |-> ##2 IRQ && IRQ_VECTOR == ssrt_pkg::VECTOR_ADDR)
    else $error("vectored interrupt missing");
  AST_WAKE_RX: assert property (receive_irq_flag && peripheral_irq_enable_reg1[ssrt_pkg::PI_RX]
    && irq_ctrl[ssrt_pkg::IC_PERIPH_EN] |=> WAKE) else $error("wake missing after reception");
  AST_WB_ACK: assert property (bus_req && !WB_ACK_O |=> WB_ACK_O ##1 !WB_ACK_O)
    else $error("bus answer not one cycle");

  COV_RX_WORD: cover property (rx_done && !fifo_full);
  COV_OVERRUN: cover property (overrun);
  COV_TX_RELOAD: cover property (tx_word_done && tx_buf_valid);
  COV_IRQ: cover property (IRQ);

endmodule
`default_nettype wire

// [verilog/ssrt_pkg.sv]
// Constants and types of the synchronous slave serial receive/transmit block
package ssrt_pkg;

  // ****************************************************************
  // Register word indices (byte address = index * 4)
  // ****************************************************************
  localparam logic [3:0] IDX_RX_STATUS = 4'h0;
  localparam logic [3:0] IDX_TX_STATUS = 4'h1;
  localparam logic [3:0] IDX_BAUD = 4'h2;
  localparam logic [3:0] IDX_IRQ_CTRL = 4'h3;
  localparam logic [3:0] IDX_PERIPHERAL_IRQ_ENABLE_REG1 = 4'h4;
  localparam logic [3:0] IDX_PERIPHERAL_IRQ_FLAG_REG1 = 4'h5;
  localparam logic [3:0] IDX_RX_DATA = 4'h6;
  localparam logic [3:0] IDX_TX_DATA = 4'h7;
  localparam logic [3:0] IDX_ALT0 = 4'h8;
  localparam logic [3:0] IDX_ALT1 = 4'h9;
  localparam logic [3:0] IDX_PORTB_DIR = 4'hA;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int RS_PORT_EN = 7;
  localparam int RS_NINTH_EN = 6;
  localparam int RS_SINGLE_EN = 5;
  localparam int RS_CONT_EN = 4;
  localparam int RS_OVERRUN = 1;
  localparam int RS_NINTH_BIT = 0;
  localparam int TS_CLK_MASTER = 7;
  localparam int TS_NINTH_EN = 6;
  localparam int TS_TX_EN = 5;
  localparam int TS_CLOCKED = 4;
  localparam int TS_SHIFT_EMPTY = 1;
  localparam int TS_NINTH_BIT = 0;
  localparam int BC_RX_IDLE = 6;
  localparam int BC_CLK_INVERT = 4;
  localparam int IC_GLOBAL_EN = 7;
  localparam int IC_PERIPH_EN = 6;
  localparam int PI_RX = 5;
  localparam int PI_TX = 4;
  localparam int ALT0_DATA_SEL = 7;
  localparam int ALT1_CLK_SEL = 0;

  // ****************************************************************
  // Reset values and fixed numbers
  // ****************************************************************
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_PORTB_DIR = 8'hFF;
  localparam logic [7:0] RX_STATUS_WMASK = 8'hF8;
  localparam logic [7:0] TX_STATUS_WMASK = 8'hFD;
  localparam logic [15:0] VECTOR_ADDR = 16'h0004;
  localparam logic [3:0] LAST_BIT_8 = 4'h7;
  localparam logic [3:0] LAST_BIT_9 = 4'h8;

  typedef struct packed {
    logic ninth;
    logic [7:0] data;
  } ssrt_word_type;

endpackage
